//--- rtl/multiphase_fault_supervisor.v
// Fault protection, strap decode and converter sampling for a multiphase rail
//
// Functional notes
// RULE1 - Full power slow overcurrent starts latchoff timer
// RULE2 - Fast overcurrent shuts rail down immediately
// RULE3 - Reduced power states use lower threshold pair
// RULE4 - Overcurrent latch cleared only by enable low (code also clears it on supplyGood low)
// RULE5 - Undervoltage trip drops ready flag
// RULE6 - Normal overvoltage drops ready flag
// RULE7 - Overvoltage ramps reference slowly to zero
// RULE8 - Overvoltage forces all pulse outputs low
// RULE9 - Below threshold during ramp, outputs go midlevel
// RULE10 - Reference at zero holds outputs low
// RULE11 - Startup uses absolute overvoltage threshold
// RULE12 - One feedforward pulse per upward reference step
// RULE13 - Phase count from first tied sense input
// RULE14 - Unused pulse outputs read as config straps
// RULE15 - Sample current monitor, full scale is max
// RULE16 - Sample each rail temperature input
// RULE17 - Slow overcurrent gone early clears timer
// RULE18 - Shutdown latches clear and restart soft start
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "fault_supervisor_map.vh"
module multiphase_fault_supervisor #(
    parameter OCP_DELAY = `OCP_DELAY_CYCLES,
    parameter REFW = 8,
    parameter ADCW = 10
) (
    input wire core_clk,
    input wire resetn,
    input wire enable,
    input wire supplyGood,
    input wire slowOcFull,
    input wire fastOcFull,
    input wire slowOcReduced,
    input wire fastOcReduced,
    input wire underVoltTrip,
    input wire overVoltRel,
    input wire overVoltAbs,
    input wire [REFW-1:0] targetRef,
    input wire [8:0] phaseTied,
    input wire [2:0] strapPins,
    input wire adcValid,
    input wire [1:0] adcChannel,
    input wire [ADCW-1:0] adcData,
    input wire [3:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWritedata,
    output reg [31:0] avsReaddata,
    output wire avsWaitrequest,
    output wire irq,
    output reg [REFW-1:0] refLevel,
    output reg [7:0] pwmLow,
    output reg [7:0] pwmMid,
    output reg [7:0] pwmRun,
    output reg auxPwmLow,
    output reg regulatorReadyFlag,
    output reg feedForwardPulse,
    output reg [3:0] activePhases,
    output reg auxRailOn
);
    localparam ST_OFF = 5'b00001;
    localparam ST_START = 5'b00010;
    localparam ST_RUN = 5'b00100;
    localparam ST_OVRAMP = 5'b01000;
    localparam ST_LATCH = 5'b10000;

    // Two-flop synchronisers for all comparator and pin inputs
    // Straps are slow levels too, so they share the synchroniser
    localparam NS = 21;
    wire [NS-1:0] rawIn = {strapPins, phaseTied, enable, supplyGood, slowOcFull, fastOcFull,
        slowOcReduced, fastOcReduced, underVoltTrip, overVoltRel, overVoltAbs};
    reg [NS-1:0] syncA_q;
    reg [NS-1:0] syncB_q;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            syncA_q <= {NS{1'b0}};
            syncB_q <= {NS{1'b0}};
        end else begin
            syncA_q <= rawIn;
            syncB_q <= syncA_q;
        end
    end
    wire [2:0] strapS = syncB_q[20:18];
    wire [8:0] tiedS = syncB_q[17:9];
    wire enS = syncB_q[8];
    wire supS = syncB_q[7];
    wire slowFullS = syncB_q[6];
    wire fastFullS = syncB_q[5];
    wire slowRedS = syncB_q[4];
    wire fastRedS = syncB_q[3];
    wire uvS = syncB_q[2];
    wire ovRelS = syncB_q[1];
    wire ovAbsS = syncB_q[0];

    reg [31:0] ctrl_q;
    reg [`EV_WIDTH-1:0] status_q;
    reg [`EV_WIDTH-1:0] mask_q;
    reg [4:0] state_q;
    reg [31:0] ocpCount_q;
    reg [7:0] rampCount_q;
    reg [2:0] ffCount_q;
    reg [2:0] cfgStrap_q;
    reg [7:0] phaseMask;
    // Pulse length sized to the down counter
    localparam [2:0] FF_PULSE = `FF_PULSE_CYCLES;
    reg ocLatched_q;
    reg ovLatched_q;

    wire enabled = enS && supS;
    // RULE3 reduced thresholds
    wire reducedPs = (ctrl_q[`CTRL_PS_LSB+1:`CTRL_PS_LSB] != 2'b00);
    wire slowOc = reducedPs ? slowRedS : slowFullS;
    wire fastOc = reducedPs ? fastRedS : fastFullS;
    wire [7:0] rampDiv = ctrl_q[`CTRL_RAMP_LSB+7:`CTRL_RAMP_LSB];
    // RULE11 absolute threshold at start
    wire ovTrip = (state_q == ST_START) ? ovAbsS : ovRelS;
    // Counter starts on the first synced cycle, so the trip lands OCP_DELAY later
    wire ocpExpire = (ocpCount_q >= OCP_DELAY - 1);
    // Divisor zero steps the reference every cycle
    wire rampTick = (rampCount_q == 8'h00);
    wire busRead = avsRead && !avsWrite;
    wire statusRead = busRead && (avsAddress == `REG_STATUS);

    // Fault events only count while the rail is live, ready lost can still fire on entry to the latched state
    reg [`EV_WIDTH-1:0] evt;
    always @* begin
        evt = {`EV_WIDTH{1'b0}};
        if (state_q == ST_RUN || state_q == ST_START) begin
            evt[`EV_OCP_DELAY] = slowOc && ocpExpire;
            evt[`EV_OCP_FAST] = fastOc;
            evt[`EV_OVP] = ovTrip;
            evt[`EV_UV] = uvS && state_q == ST_RUN;
        end
        evt[`EV_READY_LOST] = regulatorReadyFlag && (state_q != ST_RUN || uvS);
    end

    // Main state machine
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_OFF;
            ocpCount_q <= 32'h0000_0000;
            rampCount_q <= 8'h00;
            refLevel <= {REFW{1'b0}};
            ocLatched_q <= 1'b0;
            ovLatched_q <= 1'b0;
            ffCount_q <= 3'h0;
            feedForwardPulse <= 1'b0;
        end else begin
            feedForwardPulse <= (ffCount_q != 3'h0);
            if (ffCount_q != 3'h0) begin
                ffCount_q <= ffCount_q - 3'h1;
            end
            // Prescaler free runs, steps align to its wrap
            rampCount_q <= rampTick ? rampDiv : rampCount_q - 8'h01;
            // RULE4 RULE18 enable low clears
            if (!enabled) begin
                state_q <= ST_OFF;
                ocLatched_q <= 1'b0;
                ovLatched_q <= 1'b0;
                ocpCount_q <= 32'h0000_0000;
                refLevel <= {REFW{1'b0}};
            end else begin
                case (state_q)
                    ST_OFF: begin
                        // RULE18 soft start restart
                        state_q <= ST_START;
                    end
                    ST_START, ST_RUN: begin
                        // RULE1 RULE17 latchoff timer
                        if (slowOc) begin
                            ocpCount_q <= ocpCount_q + 32'h1;
                        end else begin
                            ocpCount_q <= 32'h0000_0000;
                        end
                        if (fastOc || (slowOc && ocpExpire)) begin
                            // RULE2 immediate trip
                            state_q <= ST_LATCH;
                            ocLatched_q <= 1'b1;
                        end else if (ovTrip) begin
                            // RULE7 begin slow ramp
                            state_q <= ST_OVRAMP;
                            ovLatched_q <= 1'b1;
                        end else if (rampTick && refLevel < targetRef) begin
                            // RULE12 pulse per step up
                            refLevel <= refLevel + {{(REFW-1){1'b0}}, 1'b1};
                            ffCount_q <= FF_PULSE;
                        end else if (rampTick && refLevel > targetRef) begin
                            refLevel <= refLevel - {{(REFW-1){1'b0}}, 1'b1};
                        end else if (state_q == ST_START && refLevel == targetRef) begin
                            state_q <= ST_RUN;
                        end
                    end
                    ST_OVRAMP: begin
                        // RULE7 one step per tick
                        if (refLevel == {REFW{1'b0}}) begin
                            state_q <= ST_LATCH;
                        end else if (rampTick) begin
                            refLevel <= refLevel - {{(REFW-1){1'b0}}, 1'b1};
                        end
                    end
                    ST_LATCH: begin
                        // RULE10 hold until enable cycles
                        // No bus write can leave this state
                        state_q <= ST_LATCH;
                    end
                    default: begin
                        state_q <= ST_OFF;
                    end
                endcase
            end
        end
    end

    // Output stage drive
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pwmLow <= 8'hFF;
            pwmMid <= 8'h00;
            pwmRun <= 8'h00;
            auxPwmLow <= 1'b1;
            regulatorReadyFlag <= 1'b0;
        end else begin
            // RULE5 RULE6 ready flag
            // Fast trip drops ready in the same cycle the phases go low
            regulatorReadyFlag <= (state_q == ST_RUN) && !uvS && !ovRelS && !fastOc;
            if (state_q == ST_OVRAMP) begin
                // RULE8 RULE9 low or midlevel
                pwmLow <= ovRelS ? 8'hFF : 8'h00;
                pwmMid <= ovRelS ? 8'h00 : 8'hFF;
                pwmRun <= 8'h00;
                // Aux phase follows the same low or midlevel choice
                auxPwmLow <= ovRelS;
            end else if ((state_q == ST_START || state_q == ST_RUN) && !ovTrip && !fastOc) begin
                pwmLow <= 8'h00;
                pwmMid <= 8'h00;
                pwmRun <= phaseMask;
                auxPwmLow <= !auxRailOn;
            end else begin
                // RULE10 RULE8 held low
                pwmLow <= 8'hFF;
                pwmMid <= 8'h00;
                pwmRun <= 8'h00;
                auxPwmLow <= 1'b1;
            end
        end
    end

    // Strap decode caught after enable rises, phase inputs still idle
    reg [3:0] phaseNext;
    integer i;
    always @* begin
        phaseNext = 4'd8;
        for (i = 7; i >= 4; i = i - 1) begin
            if (tiedS[i]) begin
                phaseNext = i[3:0];
            end
        end
        phaseMask = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            if (i < activePhases) begin
                phaseMask[i] = 1'b1;
            end
        end
    end
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            activePhases <= 4'd8;
            auxRailOn <= 1'b1;
            cfgStrap_q <= 3'h0;
        end else if (state_q == ST_OFF && enabled) begin
            // Taken once per start, later pin moves are ignored
            // RULE13 phase count strap
            activePhases <= phaseNext;
            auxRailOn <= !tiedS[8];
            // RULE14 unused outputs as straps
            cfgStrap_q[2] <= (phaseNext <= 4'd6) && strapS[2];
            cfgStrap_q[1] <= (phaseNext <= 4'd5) && strapS[1];
            cfgStrap_q[0] <= (phaseNext <= 4'd4) && strapS[0];
        end
    end

    // Converter samples: 0 current monitor, 1 main temp, 2 aux temp
    // RULE15 RULE16 converter capture
    wire [1:0] rdSel = (avsAddress == `REG_TEMP) ? 2'd1 :
        (avsAddress == `REG_TEMPAUX) ? 2'd2 : 2'd0;
    // Channel three is spare, writes to it are harmless
    wire [ADCW-1:0] sampleOut;
    sample_store #(.DW(ADCW), .AW(2)) samples (
        .core_clk(core_clk),
        .resetn(resetn),
        .wrEn(adcValid),
        .wrAddr(adcChannel),
        .wrData(adcData),
        .rdAddr(rdSel),
        .rdData(sampleOut)
    );

    // Bus slave: reads take two cycles for the sample memory, writes one
    reg readPend_q;
    // Writes never stall, so only reads see a wait state
    assign avsWaitrequest = busRead && !readPend_q;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            readPend_q <= 1'b0;
        end else begin
            readPend_q <= busRead && !readPend_q;
        end
    end
    always @* begin
        case (avsAddress)
            `REG_CTRL: avsReaddata = ctrl_q;
            `REG_STATUS: avsReaddata = {{(32-`EV_WIDTH){1'b0}}, status_q};
            `REG_MASK: avsReaddata = {{(32-`EV_WIDTH){1'b0}}, mask_q};
            `REG_STATE: avsReaddata = {20'h00000, ovLatched_q, ocLatched_q,
                regulatorReadyFlag, state_q, activePhases};
            `REG_IOUT, `REG_TEMP, `REG_TEMPAUX:
                avsReaddata = {{(32-ADCW){1'b0}}, sampleOut};
            `REG_STRAP: avsReaddata = {28'h0000000, auxRailOn, cfgStrap_q};
            `REG_ID: avsReaddata = `ID_VALUE;
            default: avsReaddata = 32'h0000_0000;
        endcase
    end
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `CTRL_RESET;
            mask_q <= {`EV_WIDTH{1'b0}};
            status_q <= {`EV_WIDTH{1'b0}};
        end else begin
            if (avsWrite && avsAddress == `REG_CTRL) begin
                ctrl_q <= avsWritedata;
            end
            if (avsWrite && avsAddress == `REG_MASK) begin
                mask_q <= avsWritedata[`EV_WIDTH-1:0];
            end
            // Set wins over read clear
            // An event in the taken read cycle survives to the next read
            status_q <= ((statusRead && readPend_q) ? {`EV_WIDTH{1'b0}} : status_q) | evt;
        end
    end
    assign irq = |(status_q & mask_q);
endmodule // multiphase_fault_supervisor

//--- rtl/fault_supervisor_map.vh
// Register offsets, fields, reset values and timing counts for the fault supervisor
`ifndef FAULT_SUPERVISOR_MAP_VH
`define FAULT_SUPERVISOR_MAP_VH
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_MASK 4'h2
`define REG_STATE 4'h3
`define REG_IOUT 4'h4
`define REG_TEMP 4'h5
`define REG_TEMPAUX 4'h6
`define REG_STRAP 4'h7
`define REG_ID 4'h8
`define CTRL_PS_LSB 0
`define CTRL_RAMP_LSB 8
`define CTRL_RESET 32'h0000_0400
`define EV_OCP_DELAY 0
`define EV_OCP_FAST 1
`define EV_OVP 2
`define EV_UV 3
`define EV_READY_LOST 4
`define EV_WIDTH 5
`define OCP_DELAY_NS 20000
`define CLK_PERIOD_NS 4
`define OCP_DELAY_CYCLES (`OCP_DELAY_NS / `CLK_PERIOD_NS)
`define RAMP_DIV_DEFAULT 8'h04
`define FF_PULSE_CYCLES 4
`define IOUT_FULL_SCALE 10'h3FF
`define IOUT_VOLT_MV 2500
`define ID_VALUE 32'h0000_00A5
`endif

//--- rtl/sample_store.v
// Small register memory for converter samples
`timescale 1ns/1ps
module sample_store #(
    parameter DW = 10,
    parameter AW = 2
) (
    input wire core_clk,
    input wire resetn,
    input wire wrEn,
    input wire [AW-1:0] wrAddr,
    input wire [DW-1:0] wrData,
    input wire [AW-1:0] rdAddr,
    output reg [DW-1:0] rdData
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
    // Registered read keeps timing off the bus mux
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdData <= {DW{1'b0}};
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule // sample_store

//--- bench/fault_supervisor_assertions.sv
// Port-level assertions for the fault supervisor
`timescale 1ns/1ps
`include "fault_supervisor_map.vh"
module fault_supervisor_assertions #(
    parameter OCP_DELAY = `OCP_DELAY_CYCLES
) (
    input wire core_clk,
    input wire resetn,
    input wire slowOcFull,
    input wire fastOcFull,
    input wire fastOcReduced,
    input wire underVoltTrip,
    input wire overVoltRel,
    input wire overVoltAbs,
    input wire avsRead,
    input wire avsWrite,
    input wire avsWaitrequest,
    input wire [7:0] refLevel,
    input wire [7:0] pwmLow,
    input wire [7:0] pwmMid,
    input wire [7:0] pwmRun,
    input wire regulatorReadyFlag,
    input wire feedForwardPulse
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (!resetn);
int slowRun_q;
// Slack of six covers the pin synchronisers
always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) slowRun_q <= 0;
    else slowRun_q <= slowOcFull ? slowRun_q + 1 : 0;
end
slow_oc_latch_a: assert property (slowRun_q == OCP_DELAY + 6 |-> pwmLow == 8'hFF)
    else $error("slow overcurrent did not latch");
fast_oc_latch_a: assert property ((fastOcFull && fastOcReduced) [*3] |-> ##[1:4] pwmLow == 8'hFF)
    else $error("fast overcurrent did not latch");
uv_ready_drop_a: assert property (underVoltTrip [*6] |-> !regulatorReadyFlag)
    else $error("ready high under undervoltage");
ov_ready_drop_a: assert property (overVoltRel [*6] |-> !regulatorReadyFlag)
    else $error("ready high under overvoltage");
ov_no_run_a: assert property (overVoltAbs [*6] |-> pwmRun == 8'h00)
    else $error("phases running under overvoltage");
mid_not_ready_a: assert property (pwmMid != 8'h00 |-> !regulatorReadyFlag && pwmRun == 8'h00)
    else $error("midlevel outside ramp down");
ramp_one_step_a: assert property (($past(pwmMid) != 8'h00 && refLevel != $past(refLevel))
    |-> refLevel == $past(refLevel) - 8'h01)
    else $error("reference not stepped down by one");
ready_not_low_a: assert property (regulatorReadyFlag |-> pwmLow != 8'hFF)
    else $error("ready while all phases held low");
ff_pulse_len_a: assert property ($rose(feedForwardPulse) |-> feedForwardPulse [*4] ##1 !feedForwardPulse)
    else $error("feed forward pulse length wrong");
rd_one_wait_a: assert property ($rose(avsRead) |-> avsWaitrequest ##1 !avsWaitrequest)
    else $error("read wait state wrong");
wr_no_wait_a: assert property (avsWrite |-> !avsWaitrequest)
    else $error("write stalled");
cover property ($rose(feedForwardPulse));
cover property (pwmMid != 8'h00);
cover property (slowRun_q == OCP_DELAY + 6);
endmodule // fault_supervisor_assertions
bind multiphase_fault_supervisor fault_supervisor_assertions #(.OCP_DELAY(OCP_DELAY)) i_chk (
    .core_clk(core_clk), .resetn(resetn), .slowOcFull(slowOcFull), .fastOcFull(fastOcFull),
    .fastOcReduced(fastOcReduced), .underVoltTrip(underVoltTrip), .overVoltRel(overVoltRel),
    .overVoltAbs(overVoltAbs), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWaitrequest(avsWaitrequest), .refLevel(refLevel), .pwmLow(pwmLow), .pwmMid(pwmMid),
    .pwmRun(pwmRun), .regulatorReadyFlag(regulatorReadyFlag),
    .feedForwardPulse(feedForwardPulse));

//--- bench/power_stage_model.sv
// Behavioural power stage and comparator bank at the far side
`timescale 1ns/1ps
module power_stage_model #(
    parameter OV_GAP = 4,
    parameter UV_GAP = 4,
    parameter ABS_OV = 9'h0E0
) (
    input wire core_clk,
    input wire [7:0] pwmMid,
    input wire [7:0] pwmRun,
    input wire [7:0] refLevel,
    input wire [7:0] load,
    input wire [1:0] kick,
    output wire slowOcFull,
    output wire fastOcFull,
    output wire slowOcReduced,
    output wire fastOcReduced,
    output wire underVoltTrip,
    output wire overVoltRel,
    output wire overVoltAbs
);
logic [8:0] vOut_q = 9'h000;
always @(posedge core_clk) begin
    if (kick == 2'h1) vOut_q <= 9'h0F0;
    else if (kick == 2'h2) vOut_q <= 9'h000;
    else if (pwmRun != 8'h00) vOut_q <= {1'b0, refLevel};
    else if (pwmMid == 8'h00 && vOut_q != 9'h000) vOut_q <= vOut_q - 9'h001;
end
// reduced pair lies below full pair
assign slowOcReduced = load >= 8'h40;
assign fastOcReduced = load >= 8'h60;
assign slowOcFull = load >= 8'h80;
assign fastOcFull = load >= 8'hC0;
assign underVoltTrip = vOut_q + UV_GAP < refLevel;
assign overVoltRel = vOut_q > refLevel + OV_GAP;
assign overVoltAbs = vOut_q > ABS_OV;
endmodule // power_stage_model

//--- bench/multiphase_fault_supervisor_tb.sv
// Self-checking bench for the multiphase fault supervisor
`timescale 1ns/1ps
`include "fault_supervisor_map.vh"
module multiphase_fault_supervisor_tb;
logic core_clk = 0, resetn = 0, enable = 0, supplyGood = 1, adcValid = 0;
logic avsRead = 0, avsWrite = 0, alt = 0;
logic [7:0] targetRef = 8'h40, load = 8'h00;
logic [8:0] phaseTied = 9'h000;
logic [2:0] strapPins = 3'h0;
logic [1:0] kick = 2'h0, adcChannel = 2'h0;
logic [9:0] adcData = 10'h000, d;
logic [3:0] avsAddress = 4'h0;
logic [3:0] nPh;
logic [31:0] avsWritedata = 32'h0, r;
wire slowOcFull, fastOcFull, slowOcReduced, fastOcReduced, underVoltTrip, overVoltRel;
wire overVoltAbs, avsWaitrequest, irq, auxPwmLow, regulatorReadyFlag, feedForwardPulse, auxRailOn;
wire [31:0] avsReaddata;
wire [7:0] refLevel, pwmLow, pwmMid, pwmRun;
wire [3:0] activePhases;
int n_fail = 0, n_checks = 0, seed = 48723, cyc = 0, i, k;
logic [8:0] cfg [6] = '{9'h000, 9'h080, 9'h040, 9'h020, 9'h010, 9'h100};
// Power state, load, hold cycles, expected status bits
logic [25:0] tab [8] = '{{2'h0, 8'h70, 8'h1E, 8'h00}, {2'h1, 8'h70, 8'h0A, 8'h02},
    {2'h2, 8'h70, 8'h0A, 8'h02}, {2'h3, 8'h70, 8'h0A, 8'h02}, {2'h0, 8'hC0, 8'h0A, 8'h02},
    {2'h0, 8'h90, 8'h1E, 8'h01}, {2'h0, 8'h90, 8'h0A, 8'h00}, {2'h1, 8'h50, 8'h1E, 8'h01}};
multiphase_fault_supervisor #(.OCP_DELAY(20)) i_dut (.core_clk(core_clk), .resetn(resetn),
    .enable(enable), .supplyGood(supplyGood), .slowOcFull(slowOcFull), .fastOcFull(fastOcFull),
    .slowOcReduced(slowOcReduced), .fastOcReduced(fastOcReduced), .underVoltTrip(underVoltTrip),
    .overVoltRel(overVoltRel), .overVoltAbs(overVoltAbs), .targetRef(targetRef),
    .phaseTied(phaseTied), .strapPins(strapPins), .adcValid(adcValid), .adcChannel(adcChannel),
    .adcData(adcData), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .irq(irq), .refLevel(refLevel), .pwmLow(pwmLow), .pwmMid(pwmMid), .pwmRun(pwmRun),
    .auxPwmLow(auxPwmLow), .regulatorReadyFlag(regulatorReadyFlag),
    .feedForwardPulse(feedForwardPulse), .activePhases(activePhases), .auxRailOn(auxRailOn));
power_stage_model i_ps (.core_clk(core_clk), .pwmMid(pwmMid), .pwmRun(pwmRun),
    .refLevel(refLevel), .load(load), .kick(kick), .slowOcFull(slowOcFull),
    .fastOcFull(fastOcFull), .slowOcReduced(slowOcReduced), .fastOcReduced(fastOcReduced),
    .underVoltTrip(underVoltTrip), .overVoltRel(overVoltRel), .overVoltAbs(overVoltAbs));
always #2 core_clk = ~core_clk;
always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
        n_fail++;
        wrap_up();
    end
end
task automatic wrap_up;
    if (n_fail == 0 && n_checks > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
        n_fail++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
endtask
// Request held until waitrequest sampled low
task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dat);
    logic w;
    @(posedge core_clk);
    avsAddress <= a;
    avsWritedata <= dat;
    avsWrite <= wr;
    avsRead <= !wr;
    // Falling edge values are the ones the next rising edge sees
    do begin
        @(negedge core_clk);
        w = avsWaitrequest;
        r = avsReaddata;
        @(posedge core_clk);
    end while (w !== 1'b0);
    avsWrite <= 0;
    avsRead <= 0;
endtask
function automatic logic [3:0] phases(input logic [8:0] t);
    phases = 4'h8;
    for (int j = 7; j >= 4; j--) if (t[j]) phases = 4'(j);
endfunction
// Alternates enable and supply loss as the clearing event
task automatic restart(input logic [1:0] ps);
    int j;
    @(posedge core_clk);
    alt = !alt;
    if (alt) enable <= 0;
    else supplyGood <= 0;
    tick(6);
    bus(1, `REG_CTRL, {16'h0000, `RAMP_DIV_DEFAULT, 6'h00, ps});
    @(posedge core_clk);
    enable <= 1;
    supplyGood <= 1;
    for (j = 0; j < 2000 && regulatorReadyFlag !== 1'b1; j++) @(posedge core_clk);
    chk(regulatorReadyFlag, 1);
    bus(0, `REG_STATUS, 0);
endtask
task automatic run_oc(input logic [25:0] t);
    restart(t[25:24]);
    @(posedge core_clk);
    load <= t[23:16];
    tick(t[15:8]);
    load <= 8'h00;
    tick(8);
    chk(irq, t[1]);
    chk(regulatorReadyFlag, t[1:0] == 2'h0);
    bus(0, `REG_STATUS, 0);
    chk(r[2:0], t[2:0]);
    @(posedge core_clk);
    chk(irq, 0);
    bus(0, `REG_STATE, 0);
    chk(r[10], t[1:0] != 2'h0);
endtask
// Counts feed forward pulses over a reference move
task automatic ref_step(input logic [7:0] tgt, input int n);
    int c;
    logic p;
    c = 0;
    p = 0;
    @(posedge core_clk);
    targetRef <= tgt;
    repeat (60) begin
        @(negedge core_clk);
        c += (feedForwardPulse === 1'b1 && !p);
        p = feedForwardPulse;
    end
    chk(c, n);
endtask
initial begin
    tick(4);
    resetn <= 1;
    chk(pwmLow, 8'hFF);
    bus(0, `REG_CTRL, 0);
    chk(r, `CTRL_RESET);
    bus(0, `REG_ID, 0);
    chk(r, `ID_VALUE);
    bus(0, 4'hF, 0);
    chk(r, 0);
    bus(1, `REG_MASK, 32'h2);
    bus(0, `REG_MASK, 0);
    chk(r, 32'h2);
    for (i = 0; i < 6; i++) begin
        @(posedge core_clk);
        enable <= 0;
        phaseTied <= cfg[i];
        strapPins <= 3'($random(seed));
        tick(6);
        enable <= 1;
        tick(10);
        chk(activePhases, phases(cfg[i]));
        chk(auxRailOn, !cfg[i][8]);
        nPh = phases(cfg[i]);
        chk(pwmRun, 8'hFF >> (4'h8 - nPh));
        chk(auxPwmLow, cfg[i][8]);
        bus(0, `REG_STRAP, 0);
        chk(r[2:0], strapPins & {nPh <= 4'h6, nPh <= 4'h5, nPh <= 4'h4});
    end
    phaseTied <= 9'h000;
    for (i = 0; i < 3; i++) begin
        d = i == 0 ? `IOUT_FULL_SCALE : 10'($random(seed));
        @(posedge core_clk);
        adcValid <= 1;
        adcChannel <= 2'(i);
        adcData <= d;
        @(posedge core_clk);
        adcValid <= 0;
        bus(0, 4'(`REG_IOUT + i), 0);
        chk(r, {22'h0, d});
    end
    for (i = 0; i < 8; i++) run_oc(tab[i]);
    restart(2'h0);
    k = ($random(seed) & 7) + 1;
    ref_step(8'h40 + 8'(k), k);
    ref_step(8'h40, 0);
    @(posedge core_clk);
    kick <= 2'h2;
    tick(10);
    chk(regulatorReadyFlag, 0);
    kick <= 2'h0;
    bus(0, `REG_STATUS, 0);
    chk(r[3], 1);
    restart(2'h0);
    @(posedge core_clk);
    kick <= 2'h1;
    tick(10);
    kick <= 2'h0;
    chk(regulatorReadyFlag, 0);
    chk(pwmLow, 8'hFF);
    d = 0;
    for (k = 0; k < 1000 && refLevel !== 8'h00; k++) begin
        @(posedge core_clk);
        if (pwmMid !== 8'h00) d = 1;
    end
    chk(k >= 64, 1);
    chk(d, 1);
    tick(20);
    chk(pwmLow, 8'hFF);
    chk(auxPwmLow, 1);
    bus(0, `REG_STATUS, 0);
    chk(r[2], 1);
    restart(2'h0);
    wrap_up();
end
endmodule // multiphase_fault_supervisor_tb
